// ---- gosc_pkg.sv ----
// Package for the group object send configuration block.
// Offsets, fields, reset values and timing counts.
// Assumes a 100 MHz aclk and a 32-bit AXI4-Lite register bus.
package gosc_pkg;

   // ---
   // Register offsets (byte addresses)
   // ---
   localparam logic [7:0] OFS_SIZE_CODE = 8'h00;
   localparam logic [7:0] OFS_COMM_FLAGS = 8'h04;
   localparam logic [7:0] OFS_SEND_COND = 8'h08;
   localparam logic [7:0] OFS_TIMER_TIME = 8'h0c;
   localparam logic [7:0] OFS_VALUE0 = 8'h10;
   localparam logic [7:0] OFS_VALUE3 = 8'h1c;
   localparam logic [7:0] OFS_COMMIT = 8'h20;
   localparam logic [7:0] OFS_STATUS = 8'h24;

   // ---
   // Communication flag fields
   // ---
   localparam int FLAG_UPDATE = 7;
   localparam int FLAG_TRANSMIT = 6;
   localparam int FLAG_WRITE = 4;
   localparam int FLAG_READ = 3;
   localparam int FLAG_COMM = 2;
   localparam int FLAG_PRIO_HI = 1;
   localparam logic [7:0] COMM_FLAGS_RESET = 8'hd3;
   localparam logic [7:0] COMM_FLAGS_MASK = 8'hdf;
   localparam logic [1:0] PRIO_LOW = 2'h3;
   localparam logic [1:0] PRIO_URGENT = 2'h2;
   localparam logic [1:0] PRIO_HIGH = 2'h1;
   localparam logic [1:0] PRIO_SYSTEM = 2'h0;

   // ---
   // Send condition fields
   // ---
   localparam int SEND_ON_RECEIVE = 0;
   localparam int SEND_ON_CHANGE = 1;
   localparam int SEND_ON_RISE = 2;
   localparam int SEND_TIMER_ROLE = 6;
   localparam int SEND_TIME_BASE = 7;
   localparam logic [15:0] SEND_COND_RESET = 16'h0000;
   localparam logic [15:0] SEND_COND_MASK = 16'h00c7;

   // ---
   // Object sizes and status bits
   // ---
   localparam logic [3:0] SIZE_CODE_RESET = 4'h0;
   localparam logic [3:0] SIZE_CODE_ONE_BIT = 4'h0;
   localparam logic [3:0] SIZE_CODE_LAST = 4'he;
   localparam int VALUE_BITS = 128;
   localparam int STAT_TX_BUSY = 0;
   localparam int STAT_RX_TIMEOUT = 1;
   localparam int STAT_BUS_UPDATE = 2;

   // ---
   // Timing
   // ---
   localparam longint CLK_PERIOD_NS = 10;
   localparam longint SECOND_NS = 1000000000;
   localparam int SECOND_CYCLES = int'(SECOND_NS / CLK_PERIOD_NS);
   localparam logic [5:0] SECONDS_PER_MINUTE = 6'h3c;

   typedef enum logic [1:0] {
      RESP_OKAY = 2'h0,
      RESP_SLVERR = 2'h2
   } gosc_resp_type;

endpackage : gosc_pkg

// ---- gosc_size_decode.sv ----
// Decoder from object size code to value width and storage bytes.
// Pure combinational; fed from a register of the same clock domain.
`timescale 1ns/1ns
module gosc_size_decode (
   input wire logic [3:0] size_code,
   output logic [3:0] store_bytes,
   output logic [6:0] value_bits,
   output logic one_bit,
   output logic illegal
);
   import gosc_pkg::*;

   // ---
   // Code table
   // ---
   // Bit codes keep one byte; octet codes keep that many bytes
   always_comb begin
      illegal = 1'b0;
      value_bits = 7'h08;
      store_bytes = 4'h1;
      unique case (size_code)
         4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6: begin
            value_bits = 7'(size_code) + 7'h01;
         end
         4'h7: store_bytes = 4'h1;
         4'h8: store_bytes = 4'h2;
         4'h9: store_bytes = 4'h3;
         4'ha: store_bytes = 4'h4;
         4'hb: store_bytes = 4'h6;
         4'hc: store_bytes = 4'h8;
         4'hd: store_bytes = 4'ha;
         4'he: store_bytes = 4'he;
         default: illegal = 1'b1;
      endcase
      if (size_code >= 4'h7 && !illegal) begin
         value_bits = {store_bytes, 3'h0};
      end
      one_bit = (size_code == SIZE_CODE_ONE_BIT);
   end

endmodule : gosc_size_decode

// ---- gosc_object_timer.sv ----
// Object timer: counts seconds or minutes and pulses at each period end.
// Restart and configuration come from logic on the same clock.
`timescale 1ns/1ns
module gosc_object_timer #(
   parameter int SEC_CYCLES = 100000000
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [15:0] period,
   input wire logic minutes,
   input wire logic restart,
   output logic expire
);
   import gosc_pkg::*;

   logic [31:0] prescale;
   logic [31:0] next_prescale;
   logic [5:0] seconds;
   logic [5:0] next_seconds;
   logic [15:0] units;
   logic [15:0] next_units;
   logic next_expire;
   logic sec_tick;
   logic unit_tick;
   logic active;

   // ---
   // Counting chain
   // ---
   // A zero period holds the whole chain cleared
   always_comb begin
      active = (period != 16'h0000);
      sec_tick = (prescale == 32'(SEC_CYCLES - 1));
      unit_tick = sec_tick && (!minutes || seconds == SECONDS_PER_MINUTE - 6'h01);
      next_prescale = sec_tick ? 32'h0 : prescale + 32'h1;
      next_seconds = seconds;
      if (sec_tick) begin
         next_seconds = (unit_tick || !minutes) ? 6'h00 : seconds + 6'h01;
      end
      next_units = units;
      next_expire = 1'b0;
      if (unit_tick) begin
         if (units + 16'h0001 >= period) begin
            next_units = 16'h0000;
            next_expire = 1'b1;
         end else begin
            next_units = units + 16'h0001;
         end
      end
      if (!active || restart) begin
         next_prescale = 32'h0;
         next_seconds = 6'h00;
         next_units = 16'h0000;
         next_expire = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prescale <= 32'h0;
         seconds <= 6'h00;
         units <= 16'h0000;
         expire <= 1'b0;
      end else begin
         prescale <= next_prescale;
         seconds <= next_seconds;
         units <= next_units;
         expire <= next_expire;
      end
   end

endmodule : gosc_object_timer

// ---- gosc_group_object.sv ----
// One group communication object with its send configuration.
// AXI4-Lite slave for the IP host; plain same-clock ports toward the bus side.
// Bus-side pulses last one aclk cycle.
//
// Notes on behaviour
// - Size code sets value width and bytes
// - Flags: update7 transmit6 write4 read3 comm2 prio
// - Priority 3 low, 2 urgent, 1 high, 0 system
// - Communication only while comm enable set
// - Bus reads answered only with read enable
// - Bus writes accepted only with write enable
// - Transmit only with transmit enable set
// - Update flag: read responses overwrite stored value
// - Flags reset to 0xd3
// - Bit 0: send on every IP value
// - Bit 1, multi-bit: send when value differs
// - Bit 1, one-bit: send on falling edge
// - Bit 2, one-bit: send on rising edge
// - Bit 6 picks send or receive timer
// - Bit 7 picks seconds or minutes base
// - Timer runs only with nonzero time
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ns
module gosc_group_object #(
   parameter int SEC_CYCLES = gosc_pkg::SECOND_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic bus_tx_req,
   output logic [gosc_pkg::VALUE_BITS-1:0] bus_tx_value,
   output logic [1:0] bus_tx_priority,
   input wire logic bus_tx_ack,
   input wire logic bus_write_valid,
   input wire logic bus_resp_valid,
   input wire logic [gosc_pkg::VALUE_BITS-1:0] bus_rx_value,
   input wire logic bus_read_req,
   output logic bus_read_resp_valid,
   output logic [gosc_pkg::VALUE_BITS-1:0] bus_read_resp_value
);
   import gosc_pkg::*;

   typedef enum logic {TX_IDLE, TX_SEND} gosc_tx_type;

   // ---
   // Declarations
   // ---
   logic aw_full, next_aw_full, w_full, next_w_full;
   logic [7:0] aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data;
   logic [3:0] w_strb, next_w_strb;
   logic bvalid, next_bvalid, rvalid, next_rvalid;
   logic [1:0] bresp, next_bresp, rresp, next_rresp;
   logic [31:0] rdata, next_rdata;
   logic [3:0] object_size_code, next_object_size_code;
   logic [7:0] object_comm_flags, next_object_comm_flags;
   logic [15:0] object_send_conditions, next_object_send_conditions;
   logic [15:0] timer_time, next_timer_time;
   logic [VALUE_BITS-1:0] staged, next_staged, obj_value, next_obj_value;
   logic rx_timeout, next_rx_timeout, bus_update, next_bus_update;
   gosc_tx_type tx_state, next_tx_state;
   logic [VALUE_BITS-1:0] tx_value, next_tx_value, rd_value, next_rd_value;
   logic rd_valid, next_rd_valid;
   logic [3:0] store_bytes;
   logic [6:0] value_bits;
   logic one_bit, size_illegal;
   logic do_write, commit, cfg_write, wr_hit;
   logic [VALUE_BITS-1:0] value_mask, new_value;
   logic comm_en, tx_en, trig_ip, trig_timer, trigger, take_bus, take_resp;
   logic timer_expire, timer_restart, recv_timer;
   logic [1:0] widx, ridx;

   // Byte-lane merge of a write into a register word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return res;
   endfunction : merge

   // ---
   // Size decode and timer
   // ---
   // size code decode
   gosc_size_decode u_size (
      .size_code(object_size_code),
      .store_bytes(store_bytes),
      .value_bits(value_bits),
      .one_bit(one_bit),
      .illegal(size_illegal)
   );

   gosc_object_timer #(
      .SEC_CYCLES(SEC_CYCLES)
   ) u_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .period(timer_time),
      .minutes(object_send_conditions[SEND_TIME_BASE]),
      .restart(timer_restart),
      .expire(timer_expire)
   );

   // ---
   // AXI4-Lite slave
   // ---
   // Address and data are held apart so either may arrive first
   assign s_axi_awready = !aw_full && !bvalid;
   assign s_axi_wready = !w_full && !bvalid;
   assign s_axi_arready = !rvalid;
   assign s_axi_bvalid = bvalid;
   assign s_axi_bresp = bresp;
   assign s_axi_rvalid = rvalid;
   assign s_axi_rresp = rresp;
   assign s_axi_rdata = rdata;

   always_comb begin
      next_aw_full = aw_full;
      next_aw_addr = aw_addr;
      next_w_full = w_full;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_bvalid = bvalid;
      next_bresp = bresp;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_full = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_full = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      do_write = aw_full && w_full && !bvalid;
      wr_hit = (aw_addr[1:0] == 2'h0) && (aw_addr <= OFS_STATUS);
      if (do_write) begin
         next_aw_full = 1'b0;
         next_w_full = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
   end

   // Read data is the block's live state; unmapped words answer an error
   always_comb begin
      next_rvalid = rvalid;
      next_rdata = rdata;
      next_rresp = rresp;
      ridx = s_axi_araddr[3:2];
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp = RESP_OKAY;
         next_rdata = 32'h0;
         if (s_axi_araddr == OFS_SIZE_CODE) begin
            next_rdata = {11'h0, size_illegal, 3'h0, one_bit, 1'b0, value_bits,
                          store_bytes, object_size_code};
         end else if (s_axi_araddr == OFS_COMM_FLAGS) begin
            next_rdata = {24'h0, object_comm_flags};
         end else if (s_axi_araddr == OFS_SEND_COND) begin
            next_rdata = {16'h0, object_send_conditions};
         end else if (s_axi_araddr == OFS_TIMER_TIME) begin
            next_rdata = {16'h0, timer_time};
         end else if (s_axi_araddr >= OFS_VALUE0 && s_axi_araddr <= OFS_VALUE3
                      && s_axi_araddr[1:0] == 2'h0) begin
            next_rdata = obj_value[ridx*32 +: 32];
         end else if (s_axi_araddr == OFS_COMMIT) begin
            next_rdata = 32'h0;
         end else if (s_axi_araddr == OFS_STATUS) begin
            next_rdata = {29'h0, bus_update, rx_timeout, tx_state == TX_SEND};
         end else begin
            next_rresp = RESP_SLVERR;
         end
      end
      if (rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         aw_addr <= 8'h00;
         w_full <= 1'b0;
         w_data <= 32'h0;
         w_strb <= 4'h0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         rvalid <= 1'b0;
         rdata <= 32'h0;
         rresp <= RESP_OKAY;
      end else begin
         aw_full <= next_aw_full;
         aw_addr <= next_aw_addr;
         w_full <= next_w_full;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rdata <= next_rdata;
         rresp <= next_rresp;
      end
   end

   // ---
   // Configuration registers and object value
   // ---
   always_comb begin
      widx = aw_addr[3:2];
      value_mask = ~({VALUE_BITS{1'b1}} << value_bits);
      comm_en = object_comm_flags[FLAG_COMM];
      tx_en = object_comm_flags[FLAG_TRANSMIT];
      next_object_size_code = object_size_code;
      next_object_comm_flags = object_comm_flags;
      next_object_send_conditions = object_send_conditions;
      next_timer_time = timer_time;
      next_staged = staged;
      commit = 1'b0;
      cfg_write = 1'b0;
      if (do_write) begin
         if (aw_addr == OFS_SIZE_CODE) begin
            next_object_size_code = w_strb[0] ? w_data[3:0] : object_size_code;
         end else if (aw_addr == OFS_COMM_FLAGS) begin
            // flag layout, unused bit 5 held zero
            next_object_comm_flags = merge({24'h0, object_comm_flags}, w_data, w_strb)
                                     [7:0] & COMM_FLAGS_MASK;
         end else if (aw_addr == OFS_SEND_COND) begin
            next_object_send_conditions = merge({16'h0, object_send_conditions}, w_data,
                                          w_strb)[15:0] & SEND_COND_MASK;
            cfg_write = 1'b1;
         end else if (aw_addr == OFS_TIMER_TIME) begin
            next_timer_time = merge({16'h0, timer_time}, w_data, w_strb)[15:0];
            cfg_write = 1'b1;
         end else if (aw_addr >= OFS_VALUE0 && aw_addr <= OFS_VALUE3) begin
            next_staged[widx*32 +: 32] = merge(staged[widx*32 +: 32], w_data, w_strb);
         end else if (aw_addr == OFS_COMMIT) begin
            commit = 1'b1;
         end
      end
      new_value = staged & value_mask;
      take_bus = bus_write_valid && comm_en && object_comm_flags[FLAG_WRITE];
      take_resp = bus_resp_valid && comm_en && object_comm_flags[FLAG_UPDATE];
      next_obj_value = obj_value;
      if (commit) begin
         next_obj_value = new_value;
      end else if (take_bus || take_resp) begin
         next_obj_value = bus_rx_value & value_mask;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         object_size_code <= SIZE_CODE_RESET;
         object_comm_flags <= COMM_FLAGS_RESET;
         object_send_conditions <= SEND_COND_RESET;
         timer_time <= 16'h0000;
         staged <= '0;
         obj_value <= '0;
      end else begin
         object_size_code <= next_object_size_code;
         object_comm_flags <= next_object_comm_flags;
         object_send_conditions <= next_object_send_conditions;
         timer_time <= next_timer_time;
         staged <= next_staged;
         obj_value <= next_obj_value;
      end
   end

   // ---
   // Send conditions and transmit handshake
   // ---
   // A trigger while a send is pending is dropped; the bus sees one telegram
   always_comb begin
      recv_timer = object_send_conditions[SEND_TIMER_ROLE];
      trig_ip = 1'b0;
      if (commit) begin
         if (object_send_conditions[SEND_ON_RECEIVE]) begin
            trig_ip = 1'b1;
         end
         if (one_bit) begin
            if (object_send_conditions[SEND_ON_CHANGE] && obj_value[0] && !new_value[0]) begin
               trig_ip = 1'b1;
            end
            if (object_send_conditions[SEND_ON_RISE] && !obj_value[0] && new_value[0]) begin
               trig_ip = 1'b1;
            end
         end else if (object_send_conditions[SEND_ON_CHANGE] && new_value != obj_value) begin
            trig_ip = 1'b1;
         end
      end
      trig_timer = timer_expire && !recv_timer;
      trigger = (trig_ip || trig_timer) && comm_en && tx_en;
      next_tx_state = tx_state;
      next_tx_value = tx_value;
      unique case (tx_state)
         TX_IDLE: begin
            if (trigger) begin
               next_tx_state = TX_SEND;
               next_tx_value = next_obj_value;
            end
         end
         TX_SEND: begin
            if (bus_tx_ack) begin
               next_tx_state = TX_IDLE;
            end
         end
      endcase
   end

   // ---
   // Timer restart, sticky status and bus reads
   // ---
   always_comb begin
      // zero time keeps timer idle inside the timer; restart on new setup
      timer_restart = cfg_write || (recv_timer && (take_bus || take_resp));
      next_rx_timeout = rx_timeout;
      next_bus_update = bus_update;
      if (do_write && aw_addr == OFS_STATUS && w_strb[0]) begin
         next_rx_timeout = rx_timeout && !w_data[STAT_RX_TIMEOUT];
         next_bus_update = bus_update && !w_data[STAT_BUS_UPDATE];
      end
      if (timer_expire && recv_timer) begin
         next_rx_timeout = 1'b1;
      end
      if (take_bus || take_resp) begin
         next_bus_update = 1'b1;
      end
      next_rd_valid = bus_read_req && comm_en && object_comm_flags[FLAG_READ];
      next_rd_value = next_rd_valid ? obj_value : rd_value;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_state <= TX_IDLE;
         tx_value <= '0;
         rx_timeout <= 1'b0;
         bus_update <= 1'b0;
         rd_valid <= 1'b0;
         rd_value <= '0;
      end else begin
         tx_state <= next_tx_state;
         tx_value <= next_tx_value;
         rx_timeout <= next_rx_timeout;
         bus_update <= next_bus_update;
         rd_valid <= next_rd_valid;
         rd_value <= next_rd_value;
      end
   end

   // Priority goes out as configured; system code is software's concern
   assign bus_tx_req = (tx_state == TX_SEND);
   assign bus_tx_value = tx_value;
   assign bus_tx_priority = object_comm_flags[FLAG_PRIO_HI:0];
   assign bus_read_resp_valid = rd_valid;
   assign bus_read_resp_value = rd_value;

endmodule : gosc_group_object

// ---- gosc_assertions.sv ----
// Checker for the group object block, bound to its top ports.
// Assumes one aclk domain with synchronous active-low aresetn.
`timescale 1ns/1ns
module gosc_assertions (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic bus_tx_req,
   input wire logic bus_tx_ack,
   input wire logic [gosc_pkg::VALUE_BITS-1:0] bus_tx_value,
   input wire logic [1:0] bus_tx_priority,
   input wire logic bus_read_req,
   input wire logic bus_read_resp_valid
);
   default clocking c @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ---
   // Properties
   // ---
   property p_rst_prio; $rose(aresetn) |-> bus_tx_priority == 2'h3; endproperty
   a_rst_prio: assert property (p_rst_prio) else $error("prio not low");
   property p_rd_resp; bus_read_resp_valid |-> $past(bus_read_req); endproperty
   a_rd_resp: assert property (p_rd_resp) else $error("read answer uncaused");
   property p_tx_hold; bus_tx_req && !bus_tx_ack |=> bus_tx_req && $stable(bus_tx_value); endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("telegram dropped");
   property p_ack_drop; bus_tx_req && bus_tx_ack |=> !bus_tx_req; endproperty
   a_ack_drop: assert property (p_ack_drop) else $error("req after ack");
   property p_ar_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_ar_ans: assert property (p_ar_ans) else $error("late read data");
   property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data moved");
   property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
   a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
   property p_ar_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_ar_busy: assert property (p_ar_busy) else $error("arready while busy");
endmodule : gosc_assertions
bind gosc_group_object gosc_assertions i_gosc_assertions (.*);

// ---- gosc_bus_model.sv ----
// Bus side partner: acknowledges each waiting telegram.
// Alternates prompt and slow answers so both waits are seen.
`timescale 1ns/1ns
module gosc_bus_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic bus_tx_req,
   output logic bus_tx_ack
);
   int wait_cnt;
   logic slow;
   // One-cycle ack, never twice for one telegram
   always @(posedge aclk) begin
      bus_tx_ack <= 1'b0;
      if (!aresetn) begin
         wait_cnt <= 0;
         slow <= 1'b0;
      end else if (bus_tx_req && !bus_tx_ack) begin
         wait_cnt <= wait_cnt + 1;
         if (wait_cnt >= (slow ? 4 : 0)) begin
            bus_tx_ack <= 1'b1;
            wait_cnt <= 0;
            slow <= !slow;
         end
      end
   end
endmodule : gosc_bus_model

// ---- gosc_group_object_bench.sv ----
// Bench for the group object: AXI4-Lite host plus bus-side pulses.
// Assumes gosc_bus_model acknowledges telegrams.
`timescale 1ns/1ns
module gosc_group_object_bench;
   import gosc_pkg::*;
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, bus_write_valid = 0, bus_resp_valid = 0;
   logic bus_read_req = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, bus_tx_req, bus_tx_ack, bus_read_resp_valid, rp;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd_data;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp, bus_tx_priority, rd_resp;
   logic [127:0] bus_tx_value, bus_rx_value = '0, bus_read_resp_value, last_tx;
   int miscompares = 0, comparisons = 0, sent = 0, cycles = 0, n;
   // Short second so the timer expires within the run
   gosc_group_object #(.SEC_CYCLES(20)) i_gosc_group_object (.*);
   gosc_bus_model i_gosc_bus_model (.*);
   always #5 aclk = ~aclk;
   // Telegram count and hang guard
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (bus_tx_req && bus_tx_ack) begin
         sent <= sent + 1;
         last_tx <= bus_tx_value;
      end
      if (cycles == 20000) begin
         miscompares++;
         finish_test();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // ---
   // AXI4-Lite host; valids held until taken
   // ---
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, tb;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(negedge aclk);
         ta = s_axi_awready;
         tw = s_axi_wready;
         tb = s_axi_bvalid;
         rd_resp = s_axi_bresp;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end while (!tb);
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      logic ta, tr;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(negedge aclk);
         ta = s_axi_arready;
         tr = s_axi_rvalid;
         @(posedge aclk);
         if (ta) s_axi_arvalid <= 1'b0;
      end while (!tr);
      s_axi_rready <= 1'b1;
      @(negedge aclk);
      rd_data = s_axi_rdata;
      rd_resp = s_axi_rresp;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask : rd
   // Commit an IP value and count telegrams that follow
   task automatic send(input logic [31:0] v, input int e);
      n = sent;
      wr(OFS_VALUE0, v);
      wr(OFS_COMMIT, 32'h0);
      repeat (12) @(posedge aclk);
      chk(sent - n, e);
   endtask : send
   // Bus pulse k = {read, resp, write}, then read back the stored value
   task automatic bus_in(input logic [7:0] f, input logic [2:0] k, input logic [7:0] v);
      wr(OFS_COMM_FLAGS, {24'h0, f});
      bus_rx_value <= {120'h0, v};
      {bus_read_req, bus_resp_valid, bus_write_valid} <= k;
      @(posedge aclk);
      {bus_read_req, bus_resp_valid, bus_write_valid} <= 3'h0;
      @(negedge aclk);
      rp = bus_read_resp_valid;
      @(posedge aclk);
      rd(OFS_VALUE0);
   endtask : bus_in
   task automatic t_regs;
      int nb[15] = '{1, 1, 1, 1, 1, 1, 1, 1, 2, 3, 4, 6, 8, 10, 14};
      rd(OFS_COMM_FLAGS);
      chk(rd_data, 32'hd3);
      wr(OFS_COMM_FLAGS, 32'hff);
      rd(OFS_COMM_FLAGS);
      chk(rd_data, 32'hdf);
      wr(OFS_SEND_COND, 32'hffff);
      rd(OFS_SEND_COND);
      chk(rd_data, 32'hc7);
      rd(8'h28);
      chk(rd_resp, 32'h2);
      wr(8'h26, 32'h0);
      chk(rd_resp, 32'h2);
      for (int i = 0; i < 15; i++) begin
         wr(OFS_SIZE_CODE, i);
         rd(OFS_SIZE_CODE);
         chk(rd_data & 32'h17ff0, ((i < 7 ? i + 1 : nb[i] * 8) << 8) | (nb[i] << 4) | ((i == 0) << 16));
      end
      $display("registers test done");
   endtask : t_regs
   task automatic t_send;
      for (int p = 0; p < 4; p++) begin
         wr(OFS_COMM_FLAGS, 32'h44 + p);
         chk(bus_tx_priority, p);
      end
      wr(OFS_SIZE_CODE, 32'h7);
      wr(OFS_SEND_COND, 32'h1);
      send(32'h5a, 1);
      chk(last_tx[31:0], 32'h5a);
      send(32'h5a, 1);
      wr(OFS_SEND_COND, 32'h2);
      send(32'h5a, 0);
      send(32'h3c, 1);
      wr(OFS_SEND_COND, 32'h1);
      wr(OFS_COMM_FLAGS, 32'h43);
      send(32'h11, 0);
      wr(OFS_COMM_FLAGS, 32'h07);
      send(32'h12, 0);
      wr(OFS_COMM_FLAGS, 32'h47);
      wr(OFS_SIZE_CODE, 32'h0);
      wr(OFS_SEND_COND, 32'h4);
      send(32'h1, 1);
      send(32'h0, 0);
      wr(OFS_SEND_COND, 32'h2);
      send(32'h1, 0);
      send(32'h0, 1);
      wr(OFS_SEND_COND, 32'h0);
      wr(OFS_TIMER_TIME, 32'h1);
      n = sent;
      repeat (50) @(posedge aclk);
      chk(sent - n inside {2, 3}, 1);
      wr(OFS_TIMER_TIME, 32'h0);
      repeat (12) @(posedge aclk);
      n = sent;
      repeat (50) @(posedge aclk);
      chk(sent - n, 0);
      $display("send test done");
   endtask : t_send
   task automatic t_bus;
      wr(OFS_SIZE_CODE, 32'h7);
      bus_in(8'h1d, 3'h1, 8'h77);
      chk(rd_data, 32'h77);
      bus_in(8'h1d, 3'h4, 8'h0);
      chk(rp, 32'h1);
      chk(bus_read_resp_value[31:0], 32'h77);
      bus_in(8'h18, 3'h1, 8'h66);
      chk(rd_data, 32'h77);
      bus_in(8'h84, 3'h1, 8'h55);
      chk(rd_data, 32'h77);
      bus_in(8'h84, 3'h2, 8'h44);
      chk(rd_data, 32'h44);
      bus_in(8'h84, 3'h4, 8'h0);
      chk(rp, 32'h0);
      wr(OFS_SEND_COND, 32'h40);
      wr(OFS_TIMER_TIME, 32'h1);
      repeat (30) @(posedge aclk);
      rd(OFS_STATUS);
      chk(rd_data & 32'h6, 32'h6);
      $display("bus side test done");
   endtask : t_bus
   task automatic finish_test;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs();
      t_send();
      t_bus();
      finish_test();
   end
endmodule : gosc_group_object_bench
